// ### design/laser_current_adc_dac_regs.sv
// Module: laser current reading, setting and power limit register bank
`timescale 1ns/1ps

module laser_current_adc_dac_regs
(
  input  wire logic                        mclk_i,                   // 100 MHz clock
  input  wire logic                        srst_i,                   // Sync reset, active high
  input  wire laser_regs_pkg::host_req_t   req_i,                    // Host register access
  output logic [15:0]                      rdata_o,                  // Read data, registered
  output logic                             rvalid_o,                 // Read data valid pulse
  input  wire logic                        power_controller_enable_i, // Write lock for settings
  input  wire logic                        power_loop_select_i,      // 1 power control, 0 constant current
  input  wire laser_regs_pkg::conv_in_t    conv_i,                   // Converter results
  output logic [9:0]                       source_current_setting_o, // Source DAC drive
  output logic [9:0]                       mod_current_setting_o,    // Modulation DAC drive
  output logic [6:0]                       power_limit_o             // Fault comparator limit
);

  logic [9:0] mod_current_reading_field_q;
  logic [9:0] source_current_reading_field_q;
  logic [9:0] source_current_setting_field_q;
  logic [9:0] mod_current_setting_field_q;
  logic [6:0] limit_q;
  logic [15:0] rdata_d;
  logic        write_ok;
  logic        hit_src_setting;
  logic        hit_mod_setting;
  logic        hit_pwr_limit;
  logic        hit_mod_reading;
  logic        hit_src_reading;

  // ------------------------------------------------------------
  // Converter capture
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      mod_current_reading_field_q <= laser_regs_pkg::CONV_RST;
    else if (conv_i.mod_valid)
      mod_current_reading_field_q <= conv_i.mod_code;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      source_current_reading_field_q <= laser_regs_pkg::CONV_RST;
    else if (!power_loop_select_i && conv_i.src_valid)
      source_current_reading_field_q <= conv_i.src_code;
    else if (power_loop_select_i && conv_i.mon_valid)
      source_current_reading_field_q <= conv_i.mon_code;
  end

  // Limit follows monitor readings only in power control mode; held otherwise
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      limit_q <= laser_regs_pkg::LIMIT_RST;
    else if (power_loop_select_i && conv_i.mon_valid)
      limit_q <= laser_regs_pkg::limit_t'(conv_i.mon_code >> laser_regs_pkg::LIMIT_SHIFT);
  end

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  // Shared by the write enables and the checks
  assign hit_src_setting = req_i.cmd == laser_regs_pkg::CMD_SRC_SETTING;
  assign hit_mod_setting = req_i.cmd == laser_regs_pkg::CMD_MOD_SETTING;
  assign hit_pwr_limit   = req_i.cmd == laser_regs_pkg::CMD_PWR_LIMIT;
  assign hit_mod_reading = req_i.cmd == laser_regs_pkg::CMD_MOD_READING;
  assign hit_src_reading = req_i.cmd == laser_regs_pkg::CMD_SRC_READING;

  // ------------------------------------------------------------
  // Setting registers
  // ------------------------------------------------------------
  // Writes to read-only codes find no target and fall away here
  assign write_ok = req_i.wr && !power_controller_enable_i;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      source_current_setting_field_q <= laser_regs_pkg::SET_RST;
    else if (write_ok && hit_src_setting)
      source_current_setting_field_q <= laser_regs_pkg::field_t'(req_i.wdata);
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      mod_current_setting_field_q <= laser_regs_pkg::SET_RST;
    else if (write_ok && hit_mod_setting)
      mod_current_setting_field_q <= laser_regs_pkg::field_t'(req_i.wdata);
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always_comb
  begin
    rdata_d = laser_regs_pkg::READ_ZERO;
    case (req_i.cmd)
      laser_regs_pkg::CMD_SRC_SETTING: rdata_d = laser_regs_pkg::reg_word_t'(source_current_setting_field_q);
      laser_regs_pkg::CMD_MOD_SETTING: rdata_d = laser_regs_pkg::reg_word_t'(mod_current_setting_field_q);
      laser_regs_pkg::CMD_PWR_LIMIT:   rdata_d = laser_regs_pkg::reg_word_t'(limit_q);
      laser_regs_pkg::CMD_MOD_READING: rdata_d = laser_regs_pkg::reg_word_t'(mod_current_reading_field_q);
      laser_regs_pkg::CMD_SRC_READING: rdata_d = laser_regs_pkg::reg_word_t'(source_current_reading_field_q);
      default:                         rdata_d = laser_regs_pkg::READ_ZERO;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      rdata_o  <= laser_regs_pkg::READ_ZERO;
      rvalid_o <= 1'b0;
    end
    else
    begin
      rvalid_o <= req_i.rd;
      if (req_i.rd)
        rdata_o <= rdata_d;
    end
  end

  assign source_current_setting_o = source_current_setting_field_q;
  assign mod_current_setting_o    = mod_current_setting_field_q;
  assign power_limit_o            = limit_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_locked_src_write: assert property (@(posedge mclk_i) disable iff (srst_i)
    power_controller_enable_i |=> $stable(source_current_setting_field_q))
    else $error("source setting changed while locked");

  a_locked_mod_write: assert property (@(posedge mclk_i) disable iff (srst_i)
    power_controller_enable_i |=> $stable(mod_current_setting_field_q))
    else $error("modulation setting changed while locked");

  a_src_write_lands: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.wr && !power_controller_enable_i && req_i.cmd == laser_regs_pkg::CMD_SRC_SETTING)
    |=> source_current_setting_o == $past(req_i.wdata[9:0]))
    else $error("source setting write lost");

  a_mod_write_lands: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.wr && !power_controller_enable_i && req_i.cmd == laser_regs_pkg::CMD_MOD_SETTING)
    |=> mod_current_setting_o == $past(req_i.wdata[9:0]))
    else $error("modulation setting write lost");

  a_mod_conv_capture: assert property (@(posedge mclk_i) disable iff (srst_i)
    conv_i.mod_valid |=> mod_current_reading_field_q == $past(conv_i.mod_code))
    else $error("modulation reading not captured");

  a_src_conv_capture: assert property (@(posedge mclk_i) disable iff (srst_i)
    (!power_loop_select_i && conv_i.src_valid) |=> source_current_reading_field_q == $past(conv_i.src_code))
    else $error("source reading not captured");

  a_mon_conv_capture: assert property (@(posedge mclk_i) disable iff (srst_i)
    (power_loop_select_i && conv_i.mon_valid) |=> source_current_reading_field_q == $past(conv_i.mon_code))
    else $error("monitor reading not captured");

  a_limit_tracks_mon: assert property (@(posedge mclk_i) disable iff (srst_i)
    (power_loop_select_i && conv_i.mon_valid) |=> {power_limit_o, 3'h0} == ($past(conv_i.mon_code) & 10'h3f8))
    else $error("power limit not tracking monitor");

  a_reserved_zero: assert property (@(posedge mclk_i) disable iff (srst_i)
    rvalid_o && $past(req_i.cmd) != laser_regs_pkg::CMD_PWR_LIMIT |-> rdata_o[15:10] == 6'h00)
    else $error("reserved bits not zero");

  a_read_one_cycle: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.rd && req_i.cmd == laser_regs_pkg::CMD_PWR_LIMIT) |=> rvalid_o && rdata_o == {9'h000, $past(limit_q)})
    else $error("power limit read wrong");

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  // Reset wins over any capture or write in the same cycle
  a_reset_clears: assert property (@(posedge mclk_i)
    srst_i
    |=> mod_current_reading_field_q == laser_regs_pkg::CONV_RST
        && source_current_reading_field_q == laser_regs_pkg::CONV_RST)
    else $error("readings not cleared by reset");

  a_reset_settings: assert property (@(posedge mclk_i)
    srst_i
    |=> source_current_setting_o == laser_regs_pkg::SET_RST
        && mod_current_setting_o == laser_regs_pkg::SET_RST)
    else $error("settings not cleared by reset");

  a_reset_limit: assert property (@(posedge mclk_i)
    srst_i
    |=> power_limit_o == laser_regs_pkg::LIMIT_RST && !rvalid_o
        && rdata_o == laser_regs_pkg::READ_ZERO)
    else $error("limit or read port not cleared by reset");

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  // A read returns the whole word held at its request edge
  a_limit_upper_zero: assert property (@(posedge mclk_i) disable iff (srst_i)
    (rvalid_o && $past(req_i.cmd) == laser_regs_pkg::CMD_PWR_LIMIT)
    |-> rdata_o[laser_regs_pkg::REG_W-1:laser_regs_pkg::LIMIT_W] == '0)
    else $error("limit reserved bits not zero");

  a_unmapped_read_zero: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.rd && !(hit_src_setting || hit_mod_setting || hit_pwr_limit || hit_mod_reading || hit_src_reading))
    |=> rdata_o == laser_regs_pkg::READ_ZERO)
    else $error("unmapped read not zero");

  a_rvalid_follows_rd: assert property (@(posedge mclk_i) disable iff (srst_i)
    req_i.rd
    |=> rvalid_o)
    else $error("read not answered");

  a_rvalid_one_cycle: assert property (@(posedge mclk_i) disable iff (srst_i)
    !req_i.rd
    |=> !rvalid_o)
    else $error("read valid without read");

  a_rdata_holds: assert property (@(posedge mclk_i) disable iff (srst_i)
    !req_i.rd
    |=> $stable(rdata_o))
    else $error("read data moved without read");

  a_src_setting_read: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.rd && hit_src_setting)
    |=> rdata_o == laser_regs_pkg::reg_word_t'($past(source_current_setting_o)))
    else $error("source setting read wrong");

  a_mod_setting_read: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.rd && hit_mod_setting)
    |=> rdata_o == laser_regs_pkg::reg_word_t'($past(mod_current_setting_o)))
    else $error("modulation setting read wrong");

  a_rd_wr_together: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.rd && write_ok && hit_mod_setting)
    |=> rdata_o == laser_regs_pkg::reg_word_t'($past(mod_current_setting_o))
        && mod_current_setting_o == laser_regs_pkg::field_t'($past(req_i.wdata)))
    else $error("read beside write not old value");

  a_mod_reading_read: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.rd && hit_mod_reading)
    |=> rdata_o == laser_regs_pkg::reg_word_t'($past(mod_current_reading_field_q)))
    else $error("modulation reading read torn");

  a_src_reading_read: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.rd && hit_src_reading)
    |=> rdata_o == laser_regs_pkg::reg_word_t'($past(source_current_reading_field_q)))
    else $error("source reading read torn");

  // ------------------------------------------------------------
  // Refused writes and idle cycles
  // ------------------------------------------------------------
  // Without a capture or an accepted write no stored value may move
  a_mod_reading_quiet: assert property (@(posedge mclk_i) disable iff (srst_i)
    !conv_i.mod_valid
    |=> $stable(mod_current_reading_field_q))
    else $error("modulation reading moved without conversion");

  a_src_reading_quiet: assert property (@(posedge mclk_i) disable iff (srst_i)
    (!conv_i.src_valid && !conv_i.mon_valid)
    |=> $stable(source_current_reading_field_q))
    else $error("source reading moved without conversion");

  a_mon_ignored_cc: assert property (@(posedge mclk_i) disable iff (srst_i)
    (!power_loop_select_i && conv_i.mon_valid && !conv_i.src_valid)
    |=> $stable(source_current_reading_field_q))
    else $error("monitor loaded in constant current mode");

  a_src_ignored_apc: assert property (@(posedge mclk_i) disable iff (srst_i)
    (power_loop_select_i && conv_i.src_valid && !conv_i.mon_valid)
    |=> $stable(source_current_reading_field_q))
    else $error("source loaded in power control mode");

  a_limit_not_writable: assert property (@(posedge mclk_i) disable iff (srst_i)
    !(power_loop_select_i && conv_i.mon_valid)
    |=> $stable(limit_q))
    else $error("power limit moved without monitor capture");

  a_limit_cc_held: assert property (@(posedge mclk_i) disable iff (srst_i)
    !power_loop_select_i
    |=> $stable(power_limit_o))
    else $error("power limit moved in constant current mode");

  a_src_setting_quiet: assert property (@(posedge mclk_i) disable iff (srst_i)
    !(write_ok && hit_src_setting)
    |=> $stable(source_current_setting_field_q))
    else $error("source setting moved without accepted write");

  a_mod_setting_quiet: assert property (@(posedge mclk_i) disable iff (srst_i)
    !(write_ok && hit_mod_setting)
    |=> $stable(mod_current_setting_field_q))
    else $error("modulation setting moved without accepted write");

endmodule : laser_current_adc_dac_regs

// ### design/laser_regs_pkg.sv
// Package: register map, field layouts and types of the laser current register bank
package laser_regs_pkg;

  localparam int unsigned CMD_W   = 8;
  localparam int unsigned REG_W   = 16;
  localparam int unsigned CONV_W  = 10;
  localparam int unsigned LIMIT_W = 7;
  localparam int unsigned LIMIT_SHIFT = 3;

  // Command codes
  localparam logic [7:0] CMD_SRC_SETTING = 8'h01;
  localparam logic [7:0] CMD_MOD_SETTING = 8'h02;
  localparam logic [7:0] CMD_PWR_LIMIT   = 8'h03;
  localparam logic [7:0] CMD_MOD_READING = 8'h06;
  localparam logic [7:0] CMD_SRC_READING = 8'h07;

  // Reset values
  localparam logic [9:0] CONV_RST  = 10'h000;
  localparam logic [9:0] SET_RST   = 10'h000;
  localparam logic [6:0] LIMIT_RST = 7'h00;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  // Word and field types for explicit extension and truncation
  typedef logic [REG_W-1:0]   reg_word_t;
  typedef logic [CONV_W-1:0]  field_t;
  typedef logic [LIMIT_W-1:0] limit_t;

  // Host access request
  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [7:0]       cmd;
    logic [15:0]      wdata;
  } host_req_t;

  // Converter results
  typedef struct packed {
    logic             mod_valid;
    logic [9:0]       mod_code;
    logic             src_valid;
    logic [9:0]       src_code;
    logic             mon_valid;
    logic [9:0]       mon_code;
  } conv_in_t;

endpackage : laser_regs_pkg

// ### testbench/laser_current_adc_dac_regs_bench.sv
// Self-checking bench for the laser current register bank
`timescale 1ns/1ps
module laser_current_adc_dac_regs_bench;
  logic                      mclk_i;
  logic                      srst_i;
  laser_regs_pkg::host_req_t req;
  laser_regs_pkg::conv_in_t  conv;
  logic [15:0]               rdata;
  logic                      rvalid;
  logic                      lock;
  logic                      loop_sel;
  logic [9:0]                src_set;
  logic [9:0]                mod_set;
  logic [6:0]                limit;
  int                        err_count;
  int                        checks_done;

  laser_current_adc_dac_regs DUT (.mclk_i(mclk_i), .srst_i(srst_i), .req_i(req), .rdata_o(rdata),
    .rvalid_o(rvalid), .power_controller_enable_i(lock), .power_loop_select_i(loop_sel), .conv_i(conv),
    .source_current_setting_o(src_set), .mod_current_setting_o(mod_set), .power_limit_o(limit));
  laser_host_model host (.mclk_i(mclk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] cmd, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    host.rd(cmd, d, v);
    chk({15'h0000, v}, 16'h0001);
    chk(d, exp);
    @(posedge mclk_i);
    #1 chk({15'h0000, rvalid}, 16'h0000);
    chk(rdata, exp);
  endtask : rdchk

  // One conversion pulse; source code is the inverse so a wrong pick shows
  task automatic pulse(input logic mode, input logic [2:0] which, input logic [9:0] code);
    @(posedge mclk_i);
    #1 loop_sel = mode;
    conv = '{mod_valid: which[2], mod_code: code, src_valid: which[1], src_code: ~code,
             mon_valid: which[0], mon_code: code};
    @(posedge mclk_i);
    #1 conv = '0;
  endtask : pulse

  task automatic t_reset;
    rdchk(laser_regs_pkg::CMD_SRC_SETTING, 16'h0000);
    rdchk(laser_regs_pkg::CMD_MOD_SETTING, 16'h0000);
    rdchk(laser_regs_pkg::CMD_PWR_LIMIT, 16'h0000);
    rdchk(laser_regs_pkg::CMD_MOD_READING, 16'h0000);
    rdchk(laser_regs_pkg::CMD_SRC_READING, 16'h0000);
    rdchk(8'h00, 16'h0000);
  endtask : t_reset

  task automatic t_settings;
    host.wr(laser_regs_pkg::CMD_SRC_SETTING, 16'hffff);
    rdchk(laser_regs_pkg::CMD_SRC_SETTING, 16'h03ff);
    chk({6'h00, src_set}, 16'h03ff);
    host.wr(laser_regs_pkg::CMD_MOD_SETTING, 16'hfe5a);
    rdchk(laser_regs_pkg::CMD_MOD_SETTING, 16'h025a);
    chk({6'h00, mod_set}, 16'h025a);
    @(posedge mclk_i);
    #1 lock = 1'b1;
    host.wr(laser_regs_pkg::CMD_SRC_SETTING, 16'h0155);
    rdchk(laser_regs_pkg::CMD_SRC_SETTING, 16'h03ff);
    host.wr(laser_regs_pkg::CMD_MOD_SETTING, 16'h0001);
    rdchk(laser_regs_pkg::CMD_MOD_SETTING, 16'h025a);
    @(posedge mclk_i);
    #1 lock = 1'b0;
    loop_sel = 1'b1;
    host.wr(laser_regs_pkg::CMD_PWR_LIMIT, 16'h007f);
    rdchk(laser_regs_pkg::CMD_PWR_LIMIT, 16'h0000);
  endtask : t_settings

  task automatic t_conv;
    pulse(1'b1, 3'b011, 10'h3c7);
    rdchk(laser_regs_pkg::CMD_SRC_READING, 16'h03c7);
    rdchk(laser_regs_pkg::CMD_PWR_LIMIT, 16'h0078);
    chk({9'h000, limit}, 16'h0078);
    host.wr(laser_regs_pkg::CMD_SRC_READING, 16'h0000);
    rdchk(laser_regs_pkg::CMD_SRC_READING, 16'h03c7);
    pulse(1'b1, 3'b010, 10'h0aa);
    rdchk(laser_regs_pkg::CMD_SRC_READING, 16'h03c7);
    pulse(1'b0, 3'b011, 10'h15a);
    rdchk(laser_regs_pkg::CMD_SRC_READING, 16'h02a5);
    pulse(1'b0, 3'b001, 10'h0aa);
    rdchk(laser_regs_pkg::CMD_SRC_READING, 16'h02a5);
    pulse(1'b0, 3'b100, 10'h3ff);
    rdchk(laser_regs_pkg::CMD_MOD_READING, 16'h03ff);
    host.wr(laser_regs_pkg::CMD_MOD_READING, 16'h0000);
    rdchk(laser_regs_pkg::CMD_MOD_READING, 16'h03ff);
  endtask : t_conv

  // Reset in mid-run clears every register, then a write lands again
  task automatic t_mid_reset;
    @(posedge mclk_i);
    #1 srst_i = 1'b1;
    repeat (2) @(posedge mclk_i);
    #1 srst_i = 1'b0;
    chk({6'h00, src_set}, 16'h0000);
    chk({6'h00, mod_set}, 16'h0000);
    chk(rdata, 16'h0000);
    rdchk(laser_regs_pkg::CMD_MOD_READING, 16'h0000);
    rdchk(laser_regs_pkg::CMD_SRC_READING, 16'h0000);
    rdchk(laser_regs_pkg::CMD_PWR_LIMIT, 16'h0000);
    host.wr(laser_regs_pkg::CMD_SRC_SETTING, 16'h0123);
    rdchk(laser_regs_pkg::CMD_SRC_SETTING, 16'h0123);
  endtask : t_mid_reset

  task automatic end_sim;
    $display("Checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  initial
  begin
    srst_i = 1'b1;
    lock = 1'b0;
    loop_sel = 1'b0;
    conv = '0;
    err_count = 0;
    checks_done = 0;
    repeat (8) @(posedge mclk_i);
    #1 srst_i = 1'b0;
    t_reset();
    t_settings();
    t_conv();
    t_mid_reset();
    end_sim();
  end

  // Run needs well under 200 cycles
  initial
  begin
    #20000;
    err_count++;
    end_sim();
  end
endmodule : laser_current_adc_dac_regs_bench

// ### testbench/laser_host_model.sv
// Host side model issuing register reads and writes by command code
`timescale 1ns/1ps
module laser_host_model
(
  input  wire logic                      mclk_i,    // Clock
  output laser_regs_pkg::host_req_t      req_o,     // Access request
  input  wire logic [15:0]               rdata_i,   // Read data
  input  wire logic                      rvalid_i   // Read data valid
);
  initial req_o = '0;

  // Lock state is the caller's concern; refused writes are issued on purpose only
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    @(posedge mclk_i);
    #1 req_o = '{wr: 1'b1, rd: 1'b0, cmd: cmd, wdata: d};
    @(posedge mclk_i);
    #1 req_o = '0;
  endtask : wr

  task automatic rd(input logic [7:0] cmd, output logic [15:0] d, output logic v);
    @(posedge mclk_i);
    #1 req_o = '{wr: 1'b0, rd: 1'b1, cmd: cmd, wdata: 16'h0000};
    @(posedge mclk_i);
    #1 req_o = '0;
    d = rdata_i;
    v = rvalid_i;
  endtask : rd
endmodule : laser_host_model
